// ### inc/timer_cmp2_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * second compare channel and its low-power timer sequencing.
 * Assumes a Wishbone slave with 32-bit data and byte-wide registers
 * sitting in the low lane of each word.
 */
//
// Notes on behaviour
// R1: Compare value is two bytes, upper byte at the lower address.
// R2: Compare value checked against counter continually; match sets flag.
// R3: With pin enable set, match drives the programmed level onto the pin.
// R4: Compare match raises timer interrupt only when compare irq enable set.
// R5: Free-running counter advances once every four bus clocks.
// R6: Writing the upper compare byte suppresses matching until lower written.
// R7: Writing only the lower compare byte never suppresses matching.
// R8: Either compare byte may be written alone; the other stays unchanged.
// R9: Match clocks the level to the pin whether or not flag already set.
// R10: Compare bytes RW, untouched by hardware and reset, power-on undefined.
// R11: Software writes upper byte, reads status, then writes lower byte.
// R12: In stop mode the counter halts and holds its value.
// R13: Reset loads counter with 0xFFFC; interrupt wake resumes held value.
// R14: Capture edge in stop arms; flag and data from first edge on wake.
// R15: Reset during stop discards any capture edge armed in stop.
// R16: In wait, timer 1 runs; timer 2 off when display wait-off set.
// R17: With interrupts enabled, a timer interrupt ends wait mode.
// R18: Capture edge between two third states sets flag in next fourth state.
// R19: Compare matches evaluated only in the second timer state.
// R20: Compare flag set in the fourth state after a detected match.
// R21: Wrap sets overflow in state four; status then counter low read clears.
// R22: Reset touches only counter and control registers; here reset also clears the inhibit bit read in status.
// R23: Four timer states, one per bus clock, repeat every counter increment.

`ifndef TIMER_CMP2_CFG_SVH
`define TIMER_CMP2_CFG_SVH

// Register indices; byte address is four times the index
`define CMP2_HI_IDX 6'h26
`define CMP2_LO_IDX 6'h27
`define CTRL_IDX 6'h28
`define STATUS_IDX 6'h29
`define CNT_HI_IDX 6'h2A
`define CNT_LO_IDX 6'h2B
`define CAP_HI_IDX 6'h2C
`define CAP_LO_IDX 6'h2D

// Control register fields
`define CTRL_PIN_EN 0
`define CTRL_LEVEL 1
`define CTRL_IRQ_EN 2
`define CTRL_DWO 3
`define CTRL_EDGE_RISE 4
`define CTRL_RESET 8'h00

// Status register fields
`define ST_CMP2 0
`define ST_OVF 1
`define ST_CAP 2
`define ST_INHIBIT 3

// Counter values and timing
`define CNT_RESET 16'hFFFC
`define CNT_TOP 16'hFFFF
`define TICK_CYCLES 4

`endif

// ### inc/timer_cmp2_pkg.sv
/*
 * Types of the second compare channel: timer state and state records.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package timer_cmp2_pkg;

	// One-hot timer state, one per bus clock
	typedef enum logic [3:0] {
		PH_ONE = 4'b0001,
		timer_state_two = 4'b0010,
		timer_state_three = 4'b0100,
		timer_state_four = 4'b1000
	} phase_e;

	// State initialised by reset: counter, control and sequencing
	typedef struct packed {
		phase_e ph;
		logic [15:0] cnt;
		logic [7:0] ctrl;
		logic inhibit;
		logic cmp_pend;
		logic cap_pend;
		logic [15:0] cap_tmp;
		logic stop_armed;
		logic stop_d;
		logic cap_d;
		logic [2:0] clr_arm;
		logic lvl_reg;
		logic pin;
		logic irq;
		logic wake;
		logic t2en;
		logic ack;
		logic [7:0] rdat;
	} ctl_s;

	// State that reset leaves alone
	typedef struct packed {
		logic [15:0] cmp;
		logic [15:0] cap;
		logic [2:0] flags;
	} keep_s;

endpackage

// ### rtl/timer_compare2_low_power.sv
/*
 * Second compare channel of a 16-bit free-running timer, with the
 * timer's stop and wait behaviour and flag sequencing.
 * Assumes a classic Wishbone master, synchronous mode inputs and a
 * synchronous capture pin.
 */
`timescale 1ns/1ps
`include "timer_cmp2_cfg.svh"

module timer_compare2_low_power
	import timer_cmp2_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic stop_mode_i,
	input wire logic wait_mode_i,
	input wire logic irq_enable_i,
	input wire logic capture_input_pin_i,
	output logic compare2_output_pin_o,
	output logic timer_irq_o,
	output logic wait_wake_o,
	output logic timer2_enable_o
);

	// -------------------------------------------------------------
	// State
	// -------------------------------------------------------------
	ctl_s ctl_r;
	ctl_s ctl_nxt;
	keep_s keep_r;
	keep_s keep_nxt;

	logic access;
	logic [5:0] idx;
	logic wr_hi;
	logic wr_lo;
	logic rd_status;
	logic match;
	logic edge_seen;
	logic stop_exit;

	// -------------------------------------------------------------
	// Bus decode
	// -------------------------------------------------------------
	// One access per request, on the edge that raises ack
	assign access = wb_cyc_i & wb_stb_i & ~ctl_r.ack;
	assign idx = wb_adr_i[7:2];
	assign wr_hi = access & wb_we_i & wb_sel_i[0] & (idx == `CMP2_HI_IDX);
	assign wr_lo = access & wb_we_i & wb_sel_i[0] & (idx == `CMP2_LO_IDX);
	assign rd_status = access & ~wb_we_i & (idx == `STATUS_IDX);

	// Capture edge of the selected polarity
	assign edge_seen = ctl_r.ctrl[`CTRL_EDGE_RISE] ?
		(capture_input_pin_i & ~ctl_r.cap_d) :
		(~capture_input_pin_i & ctl_r.cap_d);
	assign stop_exit = ctl_r.stop_d & ~stop_mode_i;
	assign match = (ctl_r.cnt == keep_r.cmp) & ~ctl_r.inhibit;

	// -------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------
	always_comb
	begin
		ctl_nxt = ctl_r;
		keep_nxt = keep_r;
		ctl_nxt.ack = access;
		ctl_nxt.cap_d = capture_input_pin_i;
		ctl_nxt.stop_d = stop_mode_i;

		// Timer states advance only while not stopped
		if (!stop_mode_i) // R12
		begin
			unique case (ctl_r.ph)
				PH_ONE: ctl_nxt.ph = timer_state_two; // R23
				timer_state_two: ctl_nxt.ph = timer_state_three;
				timer_state_three: ctl_nxt.ph = timer_state_four;
				timer_state_four:
				begin
					ctl_nxt.ph = PH_ONE;
					ctl_nxt.cnt = ctl_r.cnt + 16'h0001; // R5
				end
			endcase
		end

		// Compare is evaluated in the second state only
		if (!stop_mode_i && ctl_r.ph == timer_state_two && match)
			ctl_nxt.cmp_pend = 1'b1; // R19 R2

		// Clears requested by software, applied before hardware sets
		if (rd_status)
			ctl_nxt.clr_arm = keep_r.flags;
		if (wr_lo && ctl_r.clr_arm[`ST_CMP2])
		begin
			keep_nxt.flags[`ST_CMP2] = 1'b0;
			ctl_nxt.clr_arm[`ST_CMP2] = 1'b0;
		end
		if (access && !wb_we_i && idx == `CNT_LO_IDX &&
			ctl_r.clr_arm[`ST_OVF])
		begin
			keep_nxt.flags[`ST_OVF] = 1'b0; // R21
			ctl_nxt.clr_arm[`ST_OVF] = 1'b0;
		end
		if (access && !wb_we_i && idx == `CAP_LO_IDX &&
			ctl_r.clr_arm[`ST_CAP])
		begin
			keep_nxt.flags[`ST_CAP] = 1'b0;
			ctl_nxt.clr_arm[`ST_CAP] = 1'b0;
		end

		// Fourth state: compare flag, pin level and overflow
		if (!stop_mode_i && ctl_r.ph == timer_state_four)
		begin
			if (ctl_r.cmp_pend)
			begin
				keep_nxt.flags[`ST_CMP2] = 1'b1; // R20 R2
				ctl_nxt.lvl_reg = ctl_r.ctrl[`CTRL_LEVEL]; // R9
				ctl_nxt.cmp_pend = 1'b0;
			end
			if (ctl_r.cnt == `CNT_TOP)
				keep_nxt.flags[`ST_OVF] = 1'b1; // R21
			if (ctl_r.cap_pend)
			begin
				keep_nxt.flags[`ST_CAP] = 1'b1; // R18
				keep_nxt.cap = ctl_r.cap_tmp;
				ctl_nxt.cap_pend = 1'b0;
			end
		end

		// Capture edges: pending while running, armed once in stop
		if (edge_seen)
		begin
			if (stop_mode_i)
			begin
				if (!ctl_r.stop_armed)
				begin
					ctl_nxt.stop_armed = 1'b1; // R14
					ctl_nxt.cap_tmp = ctl_r.cnt + 16'h0001;
				end
			end
			else
			begin
				ctl_nxt.cap_pend = 1'b1; // R18
				ctl_nxt.cap_tmp = ctl_r.cnt + 16'h0001;
			end
		end

		// Waking from stop presents the first armed edge
		if (stop_exit && ctl_r.stop_armed)
		begin
			keep_nxt.flags[`ST_CAP] = 1'b1; // R14
			keep_nxt.cap = ctl_r.cap_tmp;
			ctl_nxt.stop_armed = 1'b0;
		end

		// Register writes; each byte stands alone
		if (wr_hi)
		begin
			keep_nxt.cmp[15:8] = wb_dat_i[7:0]; // R8 R1
			ctl_nxt.inhibit = 1'b1; // R6
		end
		if (wr_lo)
		begin
			keep_nxt.cmp[7:0] = wb_dat_i[7:0]; // R8 R1
			ctl_nxt.inhibit = 1'b0; // R7 R6
		end
		if (access && wb_we_i && wb_sel_i[0] && idx == `CTRL_IDX)
			ctl_nxt.ctrl = wb_dat_i[7:0];

		// Read data for the low lane
		ctl_nxt.rdat = 8'h00;
		if (access && !wb_we_i)
		begin
			case (idx)
				`CMP2_HI_IDX: ctl_nxt.rdat = keep_r.cmp[15:8]; // R10
				`CMP2_LO_IDX: ctl_nxt.rdat = keep_r.cmp[7:0];
				`CTRL_IDX: ctl_nxt.rdat = ctl_r.ctrl;
				`STATUS_IDX: ctl_nxt.rdat = {4'h0, ctl_r.inhibit,
					keep_r.flags};
				`CNT_HI_IDX: ctl_nxt.rdat = ctl_r.cnt[15:8];
				`CNT_LO_IDX: ctl_nxt.rdat = ctl_r.cnt[7:0];
				`CAP_HI_IDX: ctl_nxt.rdat = keep_r.cap[15:8];
				`CAP_LO_IDX: ctl_nxt.rdat = keep_r.cap[7:0];
				default: ctl_nxt.rdat = 8'h00;
			endcase
		end

		// Pin, interrupt, wake and timer 2 enable
		ctl_nxt.pin = ctl_nxt.ctrl[`CTRL_PIN_EN] & ctl_nxt.lvl_reg; // R3
		ctl_nxt.irq = keep_nxt.flags[`ST_CMP2] &
			ctl_nxt.ctrl[`CTRL_IRQ_EN]; // R4
		ctl_nxt.wake = wait_mode_i & irq_enable_i & ctl_nxt.irq; // R17
		ctl_nxt.t2en = ~(wait_mode_i & ctl_nxt.ctrl[`CTRL_DWO]); // R16
	end

	// -------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------
	// Counter, control and sequencing; reset loads the fixed count
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			ctl_r <= '{ph: PH_ONE, cnt: `CNT_RESET, // R13 R22
				ctrl: `CTRL_RESET, t2en: 1'b1, default: '0}; // R15
		end
		else
			ctl_r <= ctl_nxt;
	end

	// Compare value, capture value and flags survive reset
	always_ff @(posedge clk_sys_i)
	begin
		keep_r <= keep_nxt; // R10 R22
	end

	// Outputs straight from flip-flops
	assign wb_ack_o = ctl_r.ack;
	assign wb_dat_o = {24'h00_0000, ctl_r.rdat};
	assign compare2_output_pin_o = ctl_r.pin;
	assign timer_irq_o = ctl_r.irq;
	assign wait_wake_o = ctl_r.wake;
	assign timer2_enable_o = ctl_r.t2en;

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	sequence s_match_seen;
		!stop_mode_i && ctl_r.ph == timer_state_two && match;
	endsequence

	sequence s_run_two;
		!stop_mode_i [*2];
	endsequence

	a_phase_one_hot: assert property ( // R23
		@(posedge clk_sys_i) disable iff (reset_i)
		$onehot(ctl_r.ph))
		else $error("timer state not one-hot");

	a_count_every_four: assert property ( // R5
		@(posedge clk_sys_i) disable iff (reset_i)
		!stop_mode_i [*4] |=> ctl_r.cnt != $past(ctl_r.cnt, 4))
		else $error("counter did not advance in four cycles");

	a_count_step: assert property ( // R5
		@(posedge clk_sys_i) disable iff (reset_i)
		$changed(ctl_r.cnt) |->
		ctl_r.cnt == $past(ctl_r.cnt) + 16'h0001 &&
		$past(ctl_r.ph) == timer_state_four)
		else $error("counter moved outside fourth state");

	a_stop_holds: assert property ( // R12
		@(posedge clk_sys_i) disable iff (reset_i)
		stop_mode_i |=> $stable(ctl_r.cnt) && $stable(ctl_r.ph))
		else $error("counter moved in stop mode");

	a_match_sets_flag: assert property ( // R2
		@(posedge clk_sys_i) disable iff (reset_i)
		s_match_seen ##1 s_run_two |=> keep_r.flags[`ST_CMP2])
		else $error("match did not set compare flag");

	a_flag_in_four: assert property ( // R20
		@(posedge clk_sys_i) disable iff (reset_i)
		$rose(keep_r.flags[`ST_CMP2]) |->
		$past(ctl_r.ph) == timer_state_four && !$past(stop_mode_i))
		else $error("compare flag set outside fourth state");

	a_hi_inhibits: assert property ( // R6
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_hi && !wr_lo |=> ctl_r.inhibit)
		else $error("upper write did not inhibit compare");

	a_inhibit_holds: assert property ( // R6
		@(posedge clk_sys_i) disable iff (reset_i)
		ctl_r.inhibit && !wr_lo |=> ctl_r.inhibit)
		else $error("compare inhibit dropped before lower write");

	a_inhibit_no_pend: assert property ( // R6
		@(posedge clk_sys_i) disable iff (reset_i)
		ctl_r.inhibit && !ctl_r.cmp_pend |=> !ctl_r.cmp_pend)
		else $error("inhibited compare still matched");

	a_lo_no_inhibit: assert property ( // R7
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_lo |=> !ctl_r.inhibit)
		else $error("lower write left compare inhibited");

	a_irq_gated: assert property ( // R4
		@(posedge clk_sys_i) disable iff (reset_i)
		timer_irq_o |-> keep_r.flags[`ST_CMP2] &&
		ctl_r.ctrl[`CTRL_IRQ_EN])
		else $error("interrupt without enabled compare flag");

	a_pin_level: assert property ( // R3
		@(posedge clk_sys_i) disable iff (reset_i)
		s_match_seen ##1 s_run_two ##1 ctl_r.ctrl[`CTRL_PIN_EN] |->
		compare2_output_pin_o == $past(ctl_r.ctrl[`CTRL_LEVEL], 1))
		else $error("pin does not show programmed level");

	a_ovf_on_wrap: assert property ( // R21
		@(posedge clk_sys_i) disable iff (reset_i)
		!stop_mode_i && ctl_r.ph == timer_state_four &&
		ctl_r.cnt == `CNT_TOP |=> keep_r.flags[`ST_OVF] &&
		ctl_r.cnt == 16'h0000)
		else $error("overflow flag missing at wrap");

	a_stop_no_flag: assert property ( // R14
		@(posedge clk_sys_i) disable iff (reset_i)
		stop_mode_i && $past(stop_mode_i) && edge_seen |=>
		$stable(keep_r.flags[`ST_CAP]) || $past(!stop_mode_i))
		else $error("capture flag set during stop");

	a_wake_needs_irq: assert property ( // R17
		@(posedge clk_sys_i) disable iff (reset_i)
		wait_wake_o |-> timer_irq_o && $past(wait_mode_i) &&
		$past(irq_enable_i))
		else $error("wake without enabled interrupt in wait");

	a_timer2_wait: assert property ( // R16
		@(posedge clk_sys_i) disable iff (reset_i)
		wait_mode_i |=> timer2_enable_o == !ctl_r.ctrl[`CTRL_DWO])
		else $error("timer 2 enable wrong in wait");

	a_timer2_run: assert property ( // R16
		@(posedge clk_sys_i) disable iff (reset_i)
		!wait_mode_i |=> timer2_enable_o)
		else $error("timer 2 disabled outside wait");

	a_wake_capture: assert property ( // R14
		@(posedge clk_sys_i) disable iff (reset_i)
		stop_exit && ctl_r.stop_armed |=> keep_r.flags[`ST_CAP] &&
		keep_r.cap == $past(ctl_r.cap_tmp))
		else $error("armed capture not shown on wake");

	a_ack_one_cycle: assert property (
		@(posedge clk_sys_i) disable iff (reset_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

endmodule

// ### testbench/cpu_model.sv
/*
 * CPU stand-in: classic single-cycle Wishbone master for byte registers.
 * Assumes the slave acks every request; a missing ack raises hang_o.
 */
`timescale 1ns/1ps
module cpu_model
(
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o,
	output logic hang_o
);
	// Idle bus at time zero
	initial
	begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0000_0000;
		hang_o = 1'b0;
	end

	// One transfer, held until ack is sampled high or 64 cycles pass
	task xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= {idx, 2'b00};
		sel_o <= 4'h1;
		dat_o <= {24'h00_0000, d};
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_i !== 1'b1 && n < 64);
		hang_o <= (ack_i !== 1'b1);
		q = dat_i[7:0];
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		adr_o <= ~adr_o; // Address and data lines stop showing old values
		dat_o <= ~dat_o;
	endtask
endmodule

// ### testbench/timer_compare2_low_power_test.sv
/*
 * Testbench: register, compare, stop, wait and capture sequences.
 * Assumes the cpu_model master and the design's one-cycle ack.
 */
`timescale 1ns/1ps
`include "timer_cmp2_cfg.svh"
module timer_compare2_low_power_test;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic cyc, stb, we, ack, stop, wt, ien, cap, pin, irq, wake, t2en, hang;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dw, dr;
	logic [7:0] q;
	logic [15:0] a, b;
	int failures = 0;
	int total_checks = 0;

	// ----------------------------------------
	// Clock and instances
	// ----------------------------------------
	always #10 clk_sys_i = ~clk_sys_i;
	initial
	begin
		stop = 1'b1;
		wt = 1'b0;
		ien = 1'b0;
		cap = 1'b0;
	end
	cpu_model i_cpu_model (.clk_i(clk_sys_i), .ack_i(ack), .dat_i(dr),
		.cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
		.dat_o(dw), .hang_o(hang));
	timer_compare2_low_power i_timer_compare2_low_power (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .stop_mode_i(stop),
		.wait_mode_i(wt), .irq_enable_i(ien), .capture_input_pin_i(cap),
		.compare2_output_pin_o(pin), .timer_irq_o(irq),
		.wait_wake_o(wake), .timer2_enable_o(t2en));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task close_out;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task check(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e)
		begin
			failures++;
			$display("FAIL %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [5:0] i, input logic [7:0] d);
		logic [7:0] x;
		i_cpu_model.xfer(1'b1, i, d, x);
	endtask
	task rd(input logic [5:0] i, output logic [7:0] d);
		i_cpu_model.xfer(1'b0, i, 8'h00, d);
	endtask
	task rcnt(output logic [15:0] c);
		logic [7:0] h;
		rd(`CNT_HI_IDX, h);
		rd(`CNT_LO_IDX, c[7:0]);
		c[15:8] = h;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task wait_pin(input logic v);
		int n;
		n = 0;
		while (pin !== v && n < 200)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		check(16'(pin), 16'(v));
		if (pin !== v)
			close_out;
	endtask
	task pulse;
		@(posedge clk_sys_i);
		cap <= 1'b1;
		tick(4);
		cap <= 1'b0;
	endtask
	task run(input logic s);
		@(posedge clk_sys_i);
		stop <= s;
	endtask

	// Hang on the bus or overall watchdog
	always @(posedge hang)
	begin
		failures++;
		close_out;
	end
	initial
	begin
		tick(100000);
		failures++;
		close_out;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		tick(16);
		reset_i <= 1'b0;
		rcnt(a);
		check(a, `CNT_RESET);
		wr(`CMP2_HI_IDX, 8'hA5);
		wr(`CMP2_LO_IDX, 8'h5A);
		rd(`CMP2_HI_IDX, q);
		check(16'(q), 16'h00A5);
		wr(`CMP2_LO_IDX, 8'h3C);
		rd(`CMP2_HI_IDX, q);
		check(16'(q), 16'h00A5);
		rd(`CMP2_LO_IDX, q);
		check(16'(q), 16'h003C);
		rd(6'h3F, q);
		check(16'(q), 16'h0000);
		$display("test registers done");
		wr(`CMP2_HI_IDX, 8'h00);
		rd(`STATUS_IDX, q);
		wr(`CMP2_LO_IDX, 8'h01);
		wr(`CTRL_IDX, 8'h07);
		run(1'b0);
		wait_pin(1'b1);
		tick(2);
		check(16'(irq), 16'h0001);
		run(1'b1);
		rd(`STATUS_IDX, q);
		check(16'(q[1:0]), 16'h0003);
		rd(`CNT_LO_IDX, q);
		rd(`STATUS_IDX, q);
		check(16'(q[`ST_OVF]), 16'h0000);
		$display("test match done");
		wr(`CTRL_IDX, 8'h05);
		rd(`CNT_LO_IDX, q);
		wr(`CMP2_LO_IDX, q + 8'h03);
		rd(`CMP2_HI_IDX, q);
		check(16'(q), 16'h0000);
		run(1'b0);
		wait_pin(1'b0);
		tick(2);
		check(16'(irq), 16'h0001);
		run(1'b1);
		rd(`CNT_LO_IDX, q);
		wr(`CTRL_IDX, 8'h07);
		wr(`CMP2_LO_IDX, q + 8'h03);
		wr(`CMP2_HI_IDX, 8'h00);
		run(1'b0);
		tick(40);
		check(16'(pin), 16'h0000);
		run(1'b1);
		rd(`CNT_LO_IDX, q);
		wr(`CMP2_LO_IDX, q + 8'h03);
		run(1'b0);
		wait_pin(1'b1);
		$display("test inhibit done");
		wr(`CTRL_IDX, 8'h03);
		tick(2);
		check(16'(irq), 16'h0000);
		wr(`CTRL_IDX, 8'h0C);
		@(posedge clk_sys_i);
		wt <= 1'b1;
		ien <= 1'b1;
		tick(3);
		check(16'(wake), 16'h0001);
		check(16'(t2en), 16'h0000);
		ien <= 1'b0;
		wr(`CTRL_IDX, 8'h04);
		tick(3);
		check(16'(wake), 16'h0000);
		check(16'(t2en), 16'h0001);
		wt <= 1'b0;
		$display("test wait done");
		run(1'b1);
		rcnt(a);
		tick(20);
		rcnt(b);
		check(b, a);
		run(1'b0);
		tick(40);
		stop <= 1'b1;
		rcnt(b);
		check(b, a + 16'h000A);
		$display("test counter done");
		wr(`CTRL_IDX, 8'h10);
		run(1'b0);
		pulse;
		tick(10);
		rd(`STATUS_IDX, q);
		check(16'(q[`ST_CAP]), 16'h0001);
		rd(`CAP_LO_IDX, q);
		run(1'b1);
		rcnt(a);
		pulse;
		tick(10);
		rd(`STATUS_IDX, q);
		check(16'(q[`ST_CAP]), 16'h0000);
		run(1'b0);
		tick(3);
		rd(`STATUS_IDX, q);
		check(16'(q[`ST_CAP]), 16'h0001);
		rd(`CAP_HI_IDX, b[15:8]);
		rd(`CAP_LO_IDX, b[7:0]);
		check(b, a + 16'h0001);
		wr(`CMP2_HI_IDX, 8'h5A);
		run(1'b1);
		pulse;
		reset_i <= 1'b1;
		tick(3);
		reset_i <= 1'b0;
		rcnt(a);
		check(a, `CNT_RESET);
		rd(`CTRL_IDX, q);
		check(16'(q), 16'h0000);
		rd(`CMP2_HI_IDX, q);
		check(16'(q), 16'h005A);
		run(1'b0);
		tick(3);
		rd(`STATUS_IDX, q);
		check(16'(q[`ST_CAP]), 16'h0000);
		pulse;
		tick(10);
		rd(`STATUS_IDX, q);
		check(16'(q[`ST_CAP]), 16'h0001);
		$display("test stop done");
		close_out;
	end
endmodule
